// ---- hw/cii_pkg.sv ----
/*
  Shared constants for the card interface control port: serial timing,
  slave address, control and status bit positions, state codes.
  Assumes a 200 MHz system clock.
*/
package cii_pkg;
  // ==========================================================
  // Clocking and spike filter
  localparam int CII_CLK_NS = 5;
  localparam int CII_SPIKE_NS = 50;
  localparam int CII_SPIKE_CYC = (CII_SPIKE_NS + CII_CLK_NS - 1) / CII_CLK_NS;

  // ==========================================================
  // Slave address, byte form with direction bit at zero
  localparam logic [7:0] CII_ADDR_BASE = 8'h40;

  // ==========================================================
  // card_session_control layout
  localparam logic [7:0] CII_CTRL_RESET = 8'h00;
  localparam int CII_CB_SESSION = 0;
  localparam int CII_CB_WARM = 1;
  localparam int CII_CB_VSEL3V = 2;
  localparam int CII_CB_CLKSTOP = 3;
  localparam int CII_CB_STOPLVL = 4;
  localparam int CII_CB_DIV_LO = 5;
  localparam int CII_CB_DIV_HI = 6;
  localparam int CII_CB_IO_EN = 7;

  // ==========================================================
  // Card clock divide codes
  localparam logic [1:0] CII_DIV8 = 2'b00;
  localparam logic [1:0] CII_DIV4 = 2'b01;
  localparam logic [1:0] CII_DIV2 = 2'b10;
  localparam logic [1:0] CII_DIV1 = 2'b11;

  // ==========================================================
  // Status byte layout
  localparam int CII_SB_PRES = 0;
  localparam int CII_SB_PRESL = 1;
  localparam int CII_SB_IO = 2;
  localparam int CII_SB_SUPL = 3;
  localparam int CII_SB_PROT = 4;
  localparam int CII_SB_MUTE = 5;
  localparam int CII_SB_EARLY = 6;
  localparam int CII_SB_ACTIVE = 7;

  // ==========================================================
  // Serial slave states
  localparam logic [3:0] CII_BITS_BYTE = 4'h8;
  typedef enum logic [7:0] {
    CII_ST_IDLE = 8'b0000_0001,
    CII_ST_ADDR = 8'b0000_0010,
    CII_ST_AACK = 8'b0000_0100,
    CII_ST_WR = 8'b0000_1000,
    CII_ST_WACK = 8'b0001_0000,
    CII_ST_RD = 8'b0010_0000,
    CII_ST_RACK = 8'b0100_0000,
    CII_ST_SKIP = 8'b1000_0000
  } cii_state_t;
endpackage

// ---- hw/cii_line_if.sv ----
/*
  Filtered serial line: level plus one-cycle edge pulses.
  Driven by the spike filter, read by the slave logic on clk_sys.
*/
`timescale 1ns/1ps
interface cii_line_if;
  logic lvl;
  logic rise;
  logic fall;
  modport filt (output lvl, output rise, output fall);
  modport user (input lvl, input rise, input fall);
endinterface

// ---- hw/cii_spike_filter.sv ----
/*
  Three-flop synchroniser and spike filter for one serial bus pin.
  Assumes pin_in is asynchronous to clk_sys; idle bus level is high.
*/
`timescale 1ns/1ps
module cii_spike_filter #(
  parameter int CYC = cii_pkg::CII_SPIKE_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic pin_in,
  cii_line_if.filt line
);
  import cii_pkg::*;

  localparam int CW = $clog2(CYC + 1);

  typedef struct packed {
    logic [2:0] s;
    logic [CW-1:0] cnt;
    logic lvl;
    logic rise;
    logic fall;
  } cii_filt_t;

  cii_filt_t r;
  cii_filt_t n;

  // ==========================================================
  // Filter
  always_comb begin
    n = r;
    n.s = {r.s[1:0], pin_in};
    n.rise = 1'b0;
    n.fall = 1'b0;
    if (r.s[1] != r.s[2] || r.s[2] == r.lvl) begin
      n.cnt = '0;
    end else if (r.cnt == CW'(CYC)) begin
      n.lvl = r.s[2];
      n.rise = r.s[2];
      n.fall = ~r.s[2];
      n.cnt = '0;
    end else begin
      n.cnt = r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r <= '{s: 3'b111, cnt: '0, lvl: 1'b1, rise: 1'b0, fall: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign line.lvl = r.lvl;
  assign line.rise = r.rise;
  assign line.fall = r.fall;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_spike_hold: assert property (
    $changed(r.lvl) |-> $past(r.cnt) == CW'(CYC))
    else $error("filtered level changed before spike window");
endmodule

// ---- hw/cii_card_ctrl.sv ----
/*
  Serial slave port of a smart-card interface: one control byte written,
  one status byte read, card clock divider and host I/O gate.
  Assumes status inputs come from logic on clk_sys; bus pins and straps
  are asynchronous; Clkin of the card clock is clk_sys.
*/
`timescale 1ns/1ps

// Contract
// - Answer only to address 0x40 plus twice the three-bit strap value.
// - Address byte: upper seven bits address, bit zero the direction.
// - Writing session bit one starts activation; zero starts deactivation. Code requests each only when the bit changes value.
// - Warm reset bit starts warm reset; hardware clears it on answer or mute.
// - Control bit 2 selects card supply: one is 3 V, zero is 5 V.
// - Clock stop bit holds the card clock at the chosen level.
// - Stop level bit: one holds clock high, zero holds it low.
// - Bits 6:5 divide card clock by eight, four, two or one.
// - I/O enable passes card I/O to host line, else line floats.
// - Power-on reset clears the control byte to zero.
// - Write: START, address with direction zero, device acknowledges low.
// - Then eight data bits go to control byte, device acknowledges low.
// - Spikes up to 50 ns on clock and data are ignored.
// - Read: device acknowledges, sends status byte, master NACKs then STOP.
// - Presence change and fault bits latch until read, drive interrupt.
module cii_card_ctrl (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic addr_strap_bit0,
  input wire logic addr_strap_bit1,
  input wire logic addr_strap_bit2,
  input wire logic card_present,
  input wire logic card_io_in,
  input wire logic supply_fault,
  input wire logic prot_fault,
  input wire logic card_mute,
  input wire logic card_early,
  input wire logic card_active,
  input wire logic card_answering,
  output logic host_side_card_io_out,
  output logic host_side_card_io_oe,
  output logic [7:0] ctrl_byte,
  output logic activate_req,
  output logic deactivate_req,
  output logic warm_reset_req,
  output logic vcc_sel_3v,
  output logic card_clk,
  output logic int_n
);
  import cii_pkg::*;

  typedef struct packed {
    cii_state_t st;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic rw;
    logic sda_drv;
    logic [7:0] ctrl;
    logic act;
    logic deact;
    logic warm;
    logic presl;
    logic supl;
    logic prot;
    logic pres_d;
    logic mute_d;
    logic [2:0] div;
    logic cclk;
    logic io_q;
    logic [2:0] sp1;
    logic [2:0] sp2;
    logic [2:0] sp3;
    logic [2:0] adr;
  } cii_main_t;

  cii_main_t r;
  cii_main_t n;

  // ==========================================================
  // Bus pin filters
  cii_line_if scl ();
  cii_line_if sda ();

  cii_spike_filter #(.CYC(CII_SPIKE_CYC)) u_scl_filt (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin_in(scl_in),
    .line(scl.filt)
  );

  cii_spike_filter #(.CYC(CII_SPIKE_CYC)) u_sda_filt (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin_in(sda_in),
    .line(sda.filt)
  );

  // ==========================================================
  // Combinational helpers
  logic bus_start;
  logic bus_stop;
  logic addr_hit;
  logic commit;
  logic rd_clear;
  logic div_bit;
  logic [7:0] status_byte;

  assign bus_start = sda.fall & scl.lvl;
  assign bus_stop = sda.rise & scl.lvl;
  assign addr_hit = r.sh[7:1] == (CII_ADDR_BASE[7:1] | {4'h0, r.adr});

  always_comb begin
    status_byte = 8'h00;
    status_byte[CII_SB_PRES] = card_present;
    status_byte[CII_SB_PRESL] = r.presl;
    status_byte[CII_SB_IO] = card_io_in;
    status_byte[CII_SB_SUPL] = r.supl;
    status_byte[CII_SB_PROT] = r.prot;
    status_byte[CII_SB_MUTE] = card_mute;
    status_byte[CII_SB_EARLY] = card_early;
    status_byte[CII_SB_ACTIVE] = card_active;
  end

  always_comb begin
    case (r.ctrl[CII_CB_DIV_HI:CII_CB_DIV_LO])
      CII_DIV8: div_bit = r.div[2];
      CII_DIV4: div_bit = r.div[1];
      default: div_bit = r.div[0];
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    n = r;
    commit = 1'b0;
    rd_clear = 1'b0;
    n.act = 1'b0;
    n.deact = 1'b0;
    n.warm = 1'b0;
    n.sp1 = {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
    n.sp2 = r.sp1;
    n.sp3 = r.sp2;
    n.adr = (r.sp2 == r.sp3) ? r.sp3 : r.adr;
    case (r.st)
      CII_ST_ADDR: begin
        if (scl.rise) begin
          n.sh = {r.sh[6:0], sda.lvl};
          n.bcnt = r.bcnt + 1'b1;
        end else if (scl.fall && r.bcnt == CII_BITS_BYTE) begin
          if (addr_hit) begin
            n.st = CII_ST_AACK;
            n.rw = r.sh[0];
            n.sda_drv = 1'b1;
          end else begin
            n.st = CII_ST_SKIP;
          end
        end
      end
      CII_ST_AACK: begin
        if (scl.fall) begin
          n.bcnt = 4'h0;
          if (r.rw) begin
            n.st = CII_ST_RD;
            n.sh = status_byte;
            n.sda_drv = ~status_byte[7];
            rd_clear = 1'b1;
          end else begin
            n.st = CII_ST_WR;
            n.sda_drv = 1'b0;
          end
        end
      end
      CII_ST_WR: begin
        if (scl.rise) begin
          n.sh = {r.sh[6:0], sda.lvl};
          n.bcnt = r.bcnt + 1'b1;
        end else if (scl.fall && r.bcnt == CII_BITS_BYTE) begin
          commit = 1'b1;
          n.st = CII_ST_WACK;
          n.sda_drv = 1'b1;
        end
      end
      CII_ST_WACK: begin
        if (scl.fall) begin
          n.st = CII_ST_SKIP;
          n.sda_drv = 1'b0;
        end
      end
      CII_ST_RD: begin
        if (scl.fall) begin
          if (r.bcnt == CII_BITS_BYTE - 4'h1) begin
            n.st = CII_ST_RACK;
            n.sda_drv = 1'b0;
          end else begin
            n.sh = {r.sh[6:0], 1'b0};
            n.sda_drv = ~r.sh[6];
            n.bcnt = r.bcnt + 1'b1;
          end
        end
      end
      CII_ST_RACK: begin
        if (scl.fall) begin
          n.st = CII_ST_SKIP;
        end
      end
      CII_ST_IDLE, CII_ST_SKIP: begin
        n.sda_drv = 1'b0;
      end
      default: begin
        n.st = CII_ST_IDLE;
        n.sda_drv = 1'b0;
      end
    endcase
    if (bus_start) begin
      n.st = CII_ST_ADDR;
      n.bcnt = 4'h0;
      n.sda_drv = 1'b0;
    end else if (bus_stop) begin
      n.st = CII_ST_IDLE;
      n.sda_drv = 1'b0;
    end

    // Control byte update, write wins over hardware clear
    n.mute_d = card_mute;
    if (card_answering || (card_mute && !r.mute_d)) begin
      n.ctrl[CII_CB_WARM] = 1'b0;
    end
    if (commit) begin
      n.ctrl = r.sh;
      n.act = r.sh[CII_CB_SESSION] & ~r.ctrl[CII_CB_SESSION];
      n.deact = ~r.sh[CII_CB_SESSION] & r.ctrl[CII_CB_SESSION];
      n.warm = r.sh[CII_CB_WARM];
    end

    // Latched status, set wins over read clear
    n.pres_d = card_present;
    if (rd_clear) begin
      n.presl = 1'b0;
      n.supl = 1'b0;
      n.prot = 1'b0;
    end
    n.presl = n.presl | (card_present != r.pres_d);
    n.supl = n.supl | supply_fault;
    n.prot = n.prot | prot_fault;

    // Card clock and host I/O path
    n.div = r.div + 3'h1;
    n.cclk = r.ctrl[CII_CB_CLKSTOP] ? r.ctrl[CII_CB_STOPLVL] : div_bit;
    n.io_q = card_io_in;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.st <= CII_ST_IDLE;
      r.ctrl <= CII_CTRL_RESET;
    end else begin
      r <= n;
    end
  end

  // ==========================================================
  // Outputs
  assign sda_out = 1'b0;
  assign sda_oe = r.sda_drv;
  assign ctrl_byte = r.ctrl;
  assign activate_req = r.act;
  assign deactivate_req = r.deact;
  assign warm_reset_req = r.warm;
  assign vcc_sel_3v = r.ctrl[CII_CB_VSEL3V];
  assign host_side_card_io_out = r.io_q;
  assign host_side_card_io_oe = r.ctrl[CII_CB_IO_EN];
  assign int_n = ~(r.presl | r.supl | r.prot);
  assign card_clk = (!r.ctrl[CII_CB_CLKSTOP] &&
                     r.ctrl[CII_CB_DIV_HI:CII_CB_DIV_LO] == CII_DIV1) ? clk_sys : r.cclk;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_addr_done;
    r.st == CII_ST_ADDR && scl.fall && r.bcnt == CII_BITS_BYTE && !bus_start;
  endsequence

  sequence s_data_done;
    r.st == CII_ST_WR && scl.fall && r.bcnt == CII_BITS_BYTE && !bus_start;
  endsequence

  a_addr_miss: assert property (
    s_addr_done ##0 !addr_hit |=> r.st == CII_ST_SKIP && !sda_oe)
    else $error("foreign address acknowledged");
  a_addr_ack: assert property (
    s_addr_done ##0 addr_hit |=> sda_oe && !sda_out && r.rw == $past(r.sh[0]))
    else $error("own address not acknowledged");
  a_data_commit: assert property (
    s_data_done |=> ctrl_byte[7:2] == $past(r.sh[7:2]) && sda_oe)
    else $error("data byte not applied with acknowledge");
  a_ctrl_cause: assert property (
    $changed(ctrl_byte) && !$past(commit)
      |-> $past(ctrl_byte[CII_CB_WARM]) && !ctrl_byte[CII_CB_WARM] &&
          ctrl_byte[7:2] == $past(ctrl_byte[7:2]))
    else $error("control byte changed outside byte completion");
  a_act_pulse: assert property (
    s_data_done ##0 (r.sh[0] && !r.ctrl[0]) |=> activate_req ##1 !activate_req)
    else $error("activation request missing");
  a_warm_clear: assert property (
    card_answering && !commit |=> !ctrl_byte[CII_CB_WARM])
    else $error("warm reset bit not cleared");
  a_clk_stop: assert property (
    ctrl_byte[CII_CB_CLKSTOP] [*2] |-> card_clk == $past(ctrl_byte[CII_CB_STOPLVL]))
    else $error("card clock not held at stop level");
  a_io_float: assert property (
    !ctrl_byte[CII_CB_IO_EN] |-> !host_side_card_io_oe)
    else $error("host I/O driven while gated");
  a_io_pass: assert property (
    host_side_card_io_oe |-> host_side_card_io_out == $past(card_io_in))
    else $error("host I/O does not follow card I/O");
  a_int_hold: assert property (
    !int_n && !rd_clear |=> !int_n)
    else $error("latched status lost before read");
  a_rd_first: assert property (
    r.st == CII_ST_AACK && scl.fall && r.rw && !bus_start
      |=> r.st == CII_ST_RD && sda_oe == !$past(status_byte[7]))
    else $error("status byte first bit wrong");
endmodule

// ---- bench/cii_host_model.sv ----
/*
  Behavioural two-wire bus master standing in for the host controller.
  Assumes the bench resolves the data line to the device's sda_out while sda_oe is high, else to sda_m.
*/
`timescale 1ns/1ps
module cii_host_model (
  input wire logic clk_sys,
  input wire logic sda_line,
  output logic scl_m,
  output logic sda_m
);
  // ====================
  // Bus timing knobs
  int qtr = 25;
  bit spike = 0;

  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end

  task automatic q(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic start_c();
    sda_m <= 1'b1;
    scl_m <= 1'b1;
    q(qtr);
    sda_m <= 1'b0;
    q(qtr);
    scl_m <= 1'b0;
    q(qtr);
  endtask

  task automatic stop_c();
    sda_m <= 1'b0;
    q(qtr);
    scl_m <= 1'b1;
    q(qtr);
    sda_m <= 1'b1;
    q(qtr * 2);
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_m <= b;
    q(qtr);
    scl_m <= 1'b1;
    q(qtr);
    if (spike) begin
      scl_m <= 1'b0;
      q(10);
      scl_m <= 1'b1;
      spike = 0;
    end
    q(qtr);
    r = sda_line;
    scl_m <= 1'b0;
    q(qtr);
  endtask

  task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
  endtask

  task automatic write_c(input logic [7:0] adr, input logic [7:0] d, input int nb,
                         output logic aa, output logic ad);
    logic [7:0] rx;
    logic r;
    ad = 1'b1;
    start_c();
    byte_io(adr, rx);
    bit_io(1'b1, aa);
    if (aa === 1'b0) begin
      for (int i = 7; i > 7 - nb; i--) begin
        bit_io(d[i], r);
      end
      if (nb == 8) begin
        bit_io(1'b1, ad);
      end
    end
    stop_c();
  endtask

  task automatic read_c(input logic [7:0] adr, output logic [7:0] st, output logic aa);
    logic r;
    start_c();
    byte_io(adr, st);
    bit_io(1'b1, aa);
    byte_io(8'hFF, st);
    bit_io(1'b1, r);
    stop_c();
  endtask
endmodule

// ---- bench/cii_card_ctrl_bench.sv ----
/*
  Self-checking bench for the card interface control port.
  Data line is sda_out while sda_oe is high, else sda_m; the host model is bus master.
*/
`timescale 1ns/1ps
module cii_card_ctrl_bench;
  // ====================
  // Signals
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] strap = 3'h0;
  logic card_present = 1'b0, card_io_in = 1'b0, supply_fault = 1'b0, prot_fault = 1'b0;
  logic card_mute = 1'b0, card_early = 1'b0, card_active = 1'b0, card_answering = 1'b0;
  logic scl_m, sda_m, sda_out, sda_oe, io_out, io_oe, activate_req, deactivate_req;
  logic warm_reset_req, vcc_sel_3v, card_clk, int_n;
  logic [7:0] ctrl_byte, ctrl_exp = 8'h00, d;
  wire sda_line = sda_oe ? sda_out : sda_m;
  int bad_count = 0, checked = 0, n_act = 0, n_deact = 0, n_warm = 0, n_cclk = 0;

  always #2.5 clk_sys = ~clk_sys;

  cii_host_model i_cii_host_model (.clk_sys(clk_sys), .sda_line(sda_line),
    .scl_m(scl_m), .sda_m(sda_m));

  cii_card_ctrl i_cii_card_ctrl (.clk_sys(clk_sys), .nrst(nrst), .scl_in(scl_m),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]),
    .card_present(card_present), .card_io_in(card_io_in), .supply_fault(supply_fault),
    .prot_fault(prot_fault), .card_mute(card_mute), .card_early(card_early),
    .card_active(card_active), .card_answering(card_answering),
    .host_side_card_io_out(io_out), .host_side_card_io_oe(io_oe), .ctrl_byte(ctrl_byte),
    .activate_req(activate_req), .deactivate_req(deactivate_req),
    .warm_reset_req(warm_reset_req), .vcc_sel_3v(vcc_sel_3v), .card_clk(card_clk),
    .int_n(int_n));

  always @(posedge clk_sys) begin
    if (activate_req === 1'b1) n_act++;
    if (deactivate_req === 1'b1) n_deact++;
    if (warm_reset_req === 1'b1) n_warm++;
  end
  always @(posedge card_clk) n_cclk++;

  // ====================
  // Tasks
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] dv, input int nb, input logic ea);
    logic aa, ad;
    int a0, d0, w0;
    logic [7:0] old;
    a0 = n_act;
    d0 = n_deact;
    w0 = n_warm;
    old = ctrl_exp;
    i_cii_host_model.write_c(adr, dv, nb, aa, ad);
    chk(8'(aa), 8'(ea));
    if (ea === 1'b0 && nb == 8) begin
      chk(8'(ad), 8'h00);
      ctrl_exp = dv;
      chk(8'(n_act - a0), 8'(dv[0] & ~old[0]));
      chk(8'(n_deact - d0), 8'(~dv[0] & old[0]));
      chk(8'(n_warm - w0), 8'(dv[1]));
    end
    chk(ctrl_byte, ctrl_exp);
    chk(8'(vcc_sel_3v), 8'(ctrl_exp[2]));
    chk(8'(io_oe), 8'(ctrl_exp[7]));
  endtask

  task automatic cclk(input int exp);
    int c0;
    @(negedge clk_sys);
    c0 = n_cclk;
    repeat (64) @(negedge clk_sys);
    chk(8'(n_cclk - c0), 8'(exp));
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [7:0] exp);
    logic [7:0] st;
    logic aa;
    i_cii_host_model.read_c(adr, st, aa);
    chk(8'(aa), 8'h00);
    chk(st, exp);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ====================
  // Tests
  initial begin
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (30) @(posedge clk_sys);
    chk(ctrl_byte, 8'h00);
    chk({6'h00, int_n, sda_oe}, 8'h02);
    for (int s = 0; s < 8; s++) begin
      strap <= 3'(s);
      card_io_in <= s[0];
      repeat (8) @(posedge clk_sys);
      d = {s[2], s[1:0], 2'b00, s[0], 2'b00};
      wr(8'(8'h50 + 2 * s), 8'h66, 8, 1'b1);
      wr(8'(8'h40 + 2 * ((s + 1) % 8)), 8'hFF, 8, 1'b1);
      rd(8'(8'h41 + 2 * s), {5'h00, s[0], 2'b00});
      chk(ctrl_byte, ctrl_exp);
      wr(8'(8'h40 + 2 * s), d, 8, 1'b0);
      cclk(64 >> (3 - s[1:0]));
      if (d[7]) chk(8'(io_out), 8'(card_io_in));
    end
    $display("test address and clock rate done");
    wr(8'h4E, 8'h18, 8, 1'b0);
    cclk(0);
    chk(8'(card_clk), 8'h01);
    wr(8'h4E, 8'h08, 8, 1'b0);
    cclk(0);
    chk(8'(card_clk), 8'h00);
    $display("test clock stop done");
    i_cii_host_model.qtr = 40;
    wr(8'h4E, 8'h05, 8, 1'b0);
    wr(8'h4E, 8'h07, 8, 1'b0);
    card_answering <= 1'b1;
    @(posedge clk_sys);
    card_answering <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ctrl_exp = 8'h05;
    chk(ctrl_byte, ctrl_exp);
    wr(8'h4E, 8'h07, 8, 1'b0);
    card_mute <= 1'b1;
    repeat (4) @(posedge clk_sys);
    card_mute <= 1'b0;
    ctrl_exp = 8'h05;
    chk(ctrl_byte, ctrl_exp);
    wr(8'h4E, 8'h04, 8, 1'b0);
    wr(8'h4E, 8'h00, 8, 1'b0);
    i_cii_host_model.qtr = 25;
    $display("test session and warm reset done");
    card_present <= 1'b1;
    card_io_in <= 1'b1;
    card_active <= 1'b1;
    supply_fault <= 1'b1;
    @(posedge clk_sys);
    supply_fault <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(8'(int_n), 8'h00);
    rd(8'h4F, 8'h8F);
    chk(8'(int_n), 8'h01);
    prot_fault <= 1'b1;
    @(posedge clk_sys);
    prot_fault <= 1'b0;
    repeat (6) @(posedge clk_sys);
    chk(8'(int_n), 8'h00);
    rd(8'h4F, 8'h95);
    rd(8'h4F, 8'h85);
    $display("test status read done");
    i_cii_host_model.spike = 1;
    wr(8'h4E, 8'hA4, 8, 1'b0);
    wr(8'h4E, 8'h5A, 4, 1'b0);
    $display("test spike and cut byte done");
    close_out();
  end

  initial begin
    repeat (95000) @(posedge clk_sys);
    bad_count++;
    $display("watchdog expired");
    close_out();
  end
endmodule
